// ===== hw/svwd_supervisor.v
// supervisor: reset timer, watchdog and chip-enable gate
// How it works
// - silent kick for 1.6 s forces reset
// - watchdog clears on reset or kick edge
// - watchdog holds zero during reset
// - floating kick disables the watchdog
// - backup needs supply below trip and backup
// - backup drives warn low, reset, ignores kick
// - gate passes chip-select when not in reset
// - reset disables chip-select path
// - write in progress at a supply dip gets 18 us window
// - window expiry closes gate, output high
// - chip-select rising inside window closes gate
// - closed gate ignores chip-select input
// - power-up keeps gate closed until release
// - closed gate drives output high
// - reset lasts 200 ms, restarts on dip
// - high reset is complement of low reset
`timescale 1ns/100ps
`include "svwd_map.vh"
module svwd_supervisor #(
  parameter WDOG_CYC = `SVWD_WDOG_CYC,
  parameter RST_CYC = `SVWD_RST_CYC,
  parameter CEWIN_CYC = `SVWD_CEWIN_CYC
) (
  input wire mclk,
  input wire rst,
  input wire kickIn,
  input wire kickFloat,
  input wire belowTrip,
  input wire belowBackup,
  input wire power_fail_warn_n,
  input wire ceInN,
  output reg resetOutN,
  output reg resetOut,
  output reg powerFailWarnN,
  output reg backupMode,
  output wire ceOutN
);
  // ******************************
  // reset timeout
  // ******************************
  wire backup = belowTrip & belowBackup;
  wire rstDone;
  wire wdogDone;
  reg inReset_q;
  reg kick_q;
  reg wdFire_q;
  // a supply dip restarts the pulse; a watchdog fire starts one
  wire rstClear = belowTrip | wdFire_q;
  svwd_timer #(.WIDTH(`SVWD_TMR_W), .TERM(RST_CYC[`SVWD_TMR_W-1:0])) rstTmr (
    .mclk(mclk),
    .rst(rst),
    .clear(rstClear),
    .run(inReset_q),
    .done(rstDone)
  );
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      inReset_q <= 1'b1;
    end else if (rstClear) begin
      inReset_q <= 1'b1;
    end else if (rstDone) begin
      inReset_q <= 1'b0;
    end
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      resetOutN <= 1'b0;
      resetOut <= 1'b1;
      powerFailWarnN <= 1'b0;
      backupMode <= 1'b0;
    end else begin
      resetOutN <= ~(inReset_q | rstClear | backup);
      resetOut <= inReset_q | rstClear | backup;
      powerFailWarnN <= ~(power_fail_warn_n | backup);
      backupMode <= backup;
    end
  end
  // ******************************
  // watchdog
  // ******************************
  wire nowReset = inReset_q | rstClear;
  // kick ignored in backup and when floating
  wire wdOn = ~kickFloat & ~backup;
  wire kickEdge = wdOn & (kickIn != kick_q);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      kick_q <= 1'b0;
      wdFire_q <= 1'b0;
    end else begin
      kick_q <= kickIn;
      wdFire_q <= wdogDone & wdOn & ~nowReset;
    end
  end
  svwd_timer #(.WIDTH(`SVWD_TMR_W), .TERM(WDOG_CYC[`SVWD_TMR_W-1:0])) wdTmr (
    .mclk(mclk),
    .rst(rst),
    .clear(nowReset | kickEdge | ~wdOn),
    .run(~nowReset),
    .done(wdogDone)
  );
  // ******************************
  // chip-enable gate
  // ******************************
  localparam GATE_OFF = 2'h0;
  localparam GATE_ON = 2'h1;
  localparam GATE_WIN = 2'h2;
  reg [1:0] gate_q;
  reg [1:0] gate_d;
  wire winDone;
  svwd_timer #(.WIDTH(`SVWD_TMR_W), .TERM(CEWIN_CYC[`SVWD_TMR_W-1:0])) ceTmr (
    .mclk(mclk),
    .rst(rst),
    .clear(gate_q != GATE_WIN),
    .run(1'b1),
    .done(winDone)
  );
  always @* begin
    gate_d = gate_q;
    case (gate_q)
      GATE_OFF: begin
        if (!nowReset && !backup) begin
          gate_d = GATE_ON;
        end
      end
      GATE_ON: begin
        if (nowReset || backup) begin
          // only a supply dip grants the write window; a watchdog reset shuts at once
          gate_d = (ceInN || !belowTrip) ? GATE_OFF : GATE_WIN;
        end
      end
      GATE_WIN: begin
        if (ceInN || winDone) begin
          gate_d = GATE_OFF;
        end
      end
      default: begin
        gate_d = GATE_OFF;
      end
    endcase
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_q <= GATE_OFF;
    end else begin
      gate_q <= gate_d;
    end
  end
  // pass-through is combinational: a transmission gate has no clock delay;
  // a write still low when reset trips keeps the path only in the window
  assign ceOutN = (gate_q == GATE_ON && !nowReset && !backup) ? ceInN :
                  (gate_q == GATE_WIN && !ceInN && !winDone) ? 1'b0 :
                  (gate_q == GATE_ON && belowTrip && !ceInN) ? 1'b0 : 1'b1;
endmodule // svwd_supervisor

// ===== hw/svwd_map.vh
// timing constants for the supervisor watchdog and chip-enable gate
`ifndef SVWD_MAP_VH
`define SVWD_MAP_VH
`define SVWD_CLK_HZ 25000000
`define SVWD_WDOG_MS 1600
`define SVWD_RST_MS 200
`define SVWD_CEWIN_US 18
// watchdog is a longest time: round down
`define SVWD_WDOG_CYC ((`SVWD_CLK_HZ / 1000) * `SVWD_WDOG_MS)
// reset pulse is a least time: division rounds down
`define SVWD_RST_CYC ((`SVWD_CLK_HZ / 1000) * `SVWD_RST_MS)
// completion window is a longest time: round down
`define SVWD_CEWIN_CYC ((`SVWD_CLK_HZ / 1000000) * `SVWD_CEWIN_US)
`define SVWD_TMR_W 26
`endif

// ===== hw/svwd_timer.v
// terminal-count timer with synchronous clear
`timescale 1ns/100ps
module svwd_timer #(
  parameter WIDTH = 26,
  parameter [WIDTH-1:0] TERM = 1
) (
  input wire mclk,
  input wire rst,
  input wire clear,
  input wire run,
  output reg done
);
  reg [WIDTH-1:0] cnt_q;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (clear) begin
      cnt_q <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (run && !done) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      done <= (cnt_q == TERM - {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // svwd_timer

// ===== tb/svwd_host.sv
// host model that kicks the watchdog
`timescale 1ns/100ps
module svwd_host(input wire mclk, input wire kickEn, output reg kickIn = 1'b0);
  integer n = 0;
  // toggled at one program point every 37 cycles, so a stuck loop stops it
  always @(negedge mclk) begin
    n = kickEn ? (n + 1) % 37 : 0;
    if (n == 36) kickIn <= !kickIn;
  end
endmodule // svwd_host

// ===== tb/svwd_supervisor_assertions.sv
// port assertions for the supervisor
`timescale 1ns/100ps
module svwd_chk #(parameter WDOG_CYC = 200, RST_CYC = 50, CEWIN_CYC = 10) (
  input wire mclk, rst, kickIn, kickFloat, belowTrip, belowBackup,
  input wire ceOutN, resetOutN, resetOut, powerFailWarnN, backupMode);
  reg kickQ = 1'b0;
  integer idleQ = 0, lowQ = 0;
  // unknown pins clear idleQ but land in the counting branch for lowQ
  always @(posedge mclk) begin
    kickQ <= kickIn;
    if (resetOutN && !kickFloat && kickIn == kickQ) idleQ <= idleQ + 1;
    else idleQ <= 0;
    if (resetOutN) lowQ <= 0;
    else lowQ <= lowQ + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_CPL: assert property (resetOut == !resetOutN) else $error("pair");
  AST_TRIP: assert property (belowTrip |=> !resetOutN) else $error("trip");
  AST_RLEN: assert property ($rose(resetOutN) |-> lowQ >= RST_CYC - 1) else $error("len");
  AST_BKUP: assert property (backupMode == $past(belowTrip && belowBackup))
    else $error("backup");
  AST_BOUT: assert property ($past(backupMode) && backupMode
    |-> !powerFailWarnN && !resetOutN) else $error("backup out");
  AST_WDLT: assert property (idleQ <= WDOG_CYC + 6) else $error("late");
  AST_WDER: assert property ($fell(resetOutN) && !$past(belowTrip)
    |-> idleQ >= WDOG_CYC - 8) else $error("early");
  AST_CEW: assert property (lowQ > CEWIN_CYC + 3 |-> ceOutN) else $error("gate");
endmodule // svwd_chk
bind svwd_supervisor svwd_chk #(.WDOG_CYC(WDOG_CYC), .RST_CYC(RST_CYC), .CEWIN_CYC(CEWIN_CYC))
  i_chk (
    .mclk(mclk),
    .rst(rst),
    .kickIn(kickIn),
    .kickFloat(kickFloat),
    .belowTrip(belowTrip),
    .belowBackup(belowBackup),
    .ceOutN(ceOutN),
    .resetOutN(resetOutN),
    .resetOut(resetOut),
    .powerFailWarnN(powerFailWarnN),
    .backupMode(backupMode)
  );

// ===== tb/svwd_supervisor_tb.sv
// bench for the supervisor
`timescale 1ns/100ps
module svwd_supervisor_tb;
  reg mclk = 0, rst = 1, kickEn = 0, kickFloat = 0, belowTrip = 0, belowBackup = 0;
  reg power_fail_warn_n = 0, ceInN = 1;
  wire kickIn, resetOutN, resetOut, powerFailWarnN, backupMode, ceOutN;
  integer num_errors = 0, cmp_count = 0, seed = 32'h18bd5e64, n, i;
  always #20 mclk = !mclk;
  svwd_host i_svwd_host (.mclk(mclk), .kickEn(kickEn), .kickIn(kickIn));
  svwd_supervisor #(.WDOG_CYC(200), .RST_CYC(50), .CEWIN_CYC(10)) i_svwd_supervisor (
    .mclk(mclk),
    .rst(rst),
    .kickIn(kickIn),
    .kickFloat(kickFloat),
    .belowTrip(belowTrip),
    .belowBackup(belowBackup),
    .power_fail_warn_n(power_fail_warn_n),
    .ceInN(ceInN),
    .resetOutN(resetOutN),
    .resetOut(resetOut),
    .powerFailWarnN(powerFailWarnN),
    .backupMode(backupMode),
    .ceOutN(ceOutN)
  );
  task complete_run;
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [15:0] nm, input [3:0] seen, input [3:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge mclk);
  endtask
  // the gate stays shut whatever the host does while reset is low
  task rel;
    for (n = 0; resetOutN !== 1'b1 && n < 300; n = n + 1) begin
      ceInN = ^$random(seed);
      #1 chk("sh", ceOutN, 1);
      cyc(1);
    end
    ceInN = 1;
    cyc(2);
  endtask
  initial begin
    cyc(6);
    rst = 0;
    rel;
    chk("rl", n >= 50 && n < 300, 1);
    kickEn = 1;
    for (i = 0; i < 400; i = i + 1) begin
      ceInN = ^$random(seed);
      power_fail_warn_n = ^$random(seed);
      cyc(1);
      chk("ps", ceOutN, ceInN);
      chk("wn", powerFailWarnN, !power_fail_warn_n);
      chk("kk", resetOutN, 1);
    end
    @(kickIn);
    cyc(1);
    kickEn = 0;
    // a write left open when the watchdog bites gets no completion window
    ceInN = 0;
    for (n = 0; resetOutN === 1'b1 && n < 300; n = n + 1) cyc(1);
    chk("wd", n >= 195 && n <= 206, 1);
    #1 chk("wg", ceOutN, 1);
    rel;
    chk("rl", n >= 50 && n < 300, 1);
    kickFloat = 1;
    cyc(400);
    chk("fl", resetOutN, 1);
    kickFloat = 0;
    kickEn = 1;
    // first pass lets the window run out, second ends the write early
    for (i = 0; i < 2; i = i + 1) begin
      ceInN = 0;
      belowTrip = 1;
      cyc(5);
      belowTrip = 0;
      chk("wi", ceOutN, 0);
      if (i) begin
        ceInN = 1;
        cyc(1);
        ceInN = 0;
        #1 chk("er", ceOutN, 1);
      end
      cyc(5);
      chk("wl", ceOutN, i != 0);
      cyc(6);
      #1 chk("ex", ceOutN, 1);
      rel;
    end
    belowTrip = 1;
    belowBackup = 1;
    cyc(3);
    chk("bk", {backupMode, powerFailWarnN, resetOut, resetOutN}, 4'ha);
    belowBackup = 0;
    cyc(2);
    chk("bt", backupMode, 0);
    belowTrip = 0;
    rel;
    complete_run;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    complete_run;
  end
endmodule // svwd_supervisor_tb
